// >>> hw/j1939_rx_pkg.sv
// Package for the extended-frame receive queue with identifier decoding.
// Assumes a 32-bit Avalon-MM register port with byte addresses.
package j1939_rx_pkg;
   // Queue and frame geometry
   localparam int QUEUE_DEPTH = 16;
   localparam int CNT_W = 5;
   localparam int ID_W = 29;
   localparam int BASE_W = 11;
   localparam int EXT_W = 18;
   localparam int ADDR_W = 6;
   localparam logic [3:0] DLC_MAX = 4'h8;
   // PDU format boundary: below it destination specific, at or above broadcast
   localparam logic [7:0] PF_BCAST_MIN = 8'hf0;
   // Identifier field positions
   localparam int PRIO_LSB = 26;
   localparam int RSV_BIT = 25;
   localparam int DP_BIT = 24;
   localparam int PF_LSB = 16;
   localparam int PS_LSB = 8;
   localparam int SA_LSB = 0;
   // Register byte offsets
   localparam logic [ADDR_W-1:0] REG_CTRL = 6'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 6'h04;
   localparam logic [ADDR_W-1:0] REG_POP = 6'h08;
   localparam logic [ADDR_W-1:0] REG_ID = 6'h0c;
   localparam logic [ADDR_W-1:0] REG_DATA_LO = 6'h10;
   localparam logic [ADDR_W-1:0] REG_DATA_HI = 6'h14;
   localparam logic [ADDR_W-1:0] REG_DLC = 6'h18;
   localparam logic [ADDR_W-1:0] REG_DECODE = 6'h1c;
   localparam logic [ADDR_W-1:0] REG_PGN = 6'h20;
   localparam logic [ADDR_W-1:0] REG_IRQ_STS = 6'h24;
   localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 6'h28;
   // Control and status bit positions
   localparam int CTRL_SETUP = 0;
   localparam int CTRL_FLUSH = 1;
   localparam int STS_LOST = 8;
   localparam int STS_ARMED = 9;
   localparam int IRQ_RX = 0;
   localparam int IRQ_LOST = 1;
   localparam int IRQ_W = 2;
   localparam int DEC_PDU1 = 29;
   localparam int DEC_PDU2 = 30;
   // Reset values
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
   localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
endpackage

// >>> hw/extended_receive_all_block.sv
// Receive queue for 29-bit identifier frames with J1939 field decoding.
// Assumes frames arrive as one-cycle strobes synchronous to clk_sys and
// that software reaches the registers over Avalon-MM with waitrequest.
//
// Contract
// [R1] Setup is pulsed for one cycle to arm reception; without it nothing is configured.
// [R2] A flush empties the queue at once; without it the queue is untouched.
// [R3] Each frame carries up to 8 data bytes plus a length code for the valid ones.
// [R4] The pending count equals the frames waiting, zero when empty.
// [R5] Each popping read lowers the pending count by exactly one.
// [R6] A frame arriving on a full queue is dropped and raises the lost flag.
// [R7] The queue holds sixteen frames before overflow applies.
// [R8] Only extended frames with a 29-bit identifier are taken.
// [R9] The identifier is the 11-bit base part followed by the 18-bit extension.
// [R10] Bits 28..26 priority, 25 reserved, 24 data page, 23..16 PF, 15..8 PS, 7..0 SA.
// [R11] The parameter group number is built from PF and PS.
// [R12] PF 0..239 marks a destination-specific frame with PS as destination.
// [R13] PF 240..255 marks a broadcast frame.
// [R14] Proprietary frames in either format are never rejected.
// [R15] Only the low five bits of the top identifier byte are decoded.
// [R16] The identifier word is the 29-bit value right aligned, upper bits zero.
//
// Register access over Avalon-MM and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module extended_receive_all_block #(
   parameter int DEPTH = j1939_rx_pkg::QUEUE_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Avalon-MM slave
   input wire logic [j1939_rx_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Received frame strobe from the CAN controller
   input wire logic frm_valid,
   input wire logic frm_ide,
   input wire logic [j1939_rx_pkg::BASE_W-1:0] frm_base_id,
   input wire logic [j1939_rx_pkg::EXT_W-1:0] frm_ext_id,
   input wire logic [3:0] frm_dlc,
   input wire logic [63:0] frm_data,
   // Interrupt
   output logic irq
);
   import j1939_rx_pkg::*;

   localparam int PW = $clog2(DEPTH);

   logic [ID_W-1:0] mem_id [DEPTH];
   logic [3:0] mem_dlc [DEPTH];
   logic [63:0] mem_data [DEPTH];
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] rd_ptr_q;
   logic [CNT_W-1:0] cnt_q;
   logic armed_q;
   logic lost_q;
   logic [IRQ_W-1:0] irq_sts_q;
   logic [IRQ_W-1:0] irq_mask_q;
   logic wr_done;
   logic rd_done;
   logic setup_p;
   logic flush_p;
   logic full;
   logic arrive;
   logic push;
   logic pop;
   logic drop;
   logic [ID_W-1:0] hid;
   logic [2:0] prio;
   logic rsv;
   logic dp;
   logic [7:0] pf;
   logic [7:0] ps;
   logic [7:0] sa;
   logic pdu1;
   logic [31:0] rd_d;
   logic [IRQ_W-1:0] irq_set;

   // Access completes on the edge where waitrequest is seen low
   assign wr_done = avs_write & ~avs_waitrequest;
   assign rd_done = avs_read & ~avs_waitrequest;
   assign setup_p = wr_done & (avs_address == REG_CTRL) & avs_byteenable[0] & avs_writedata[CTRL_SETUP];
   assign flush_p = wr_done & (avs_address == REG_CTRL) & avs_byteenable[0] & avs_writedata[CTRL_FLUSH];

   // Queue handshake terms
   assign full = (cnt_q == CNT_W'(DEPTH)); // [R7]
   // Standard-format frames are not taken, whatever the identifier class [R8] [R14]
   assign arrive = armed_q & frm_valid & frm_ide;
   assign push = arrive & ~full & ~flush_p;
   assign drop = arrive & full & ~flush_p;
   // A pop on an empty queue is ignored so the count can never wrap
   assign pop = rd_done & (avs_address == REG_POP) & (cnt_q != CNT_RST) & ~flush_p;

   // Reception is armed by the one-cycle setup pulse
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         armed_q <= 1'b0;
      end else if (setup_p) begin
         armed_q <= 1'b1; // [R1]
      end
   end

   // Frame storage; no reset needed since the count guards every read
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_id[wr_ptr_q] <= {frm_base_id, frm_ext_id}; // [R9]
         mem_dlc[wr_ptr_q] <= (frm_dlc > DLC_MAX) ? DLC_MAX : frm_dlc; // [R3]
         mem_data[wr_ptr_q] <= frm_data;
      end
   end

   // Pointers and pending count; flush discards everything in flight
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q <= CNT_RST;
      end else if (flush_p) begin
         wr_ptr_q <= '0; // [R2]
         rd_ptr_q <= '0;
         cnt_q <= CNT_RST;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1; // [R4]
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1; // [R5]
         end
      end
   end

   // Lost flag is sticky; a drop in the flush cycle still wins
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         lost_q <= 1'b0;
      end else if (drop || (arrive && full)) begin
         lost_q <= 1'b1; // [R6]
      end else if (flush_p || setup_p) begin
         lost_q <= 1'b0;
      end
   end

   // Head frame decoding; bits 31..29 of the identifier word never exist here
   assign hid = mem_id[rd_ptr_q];
   assign prio = hid[PRIO_LSB +: 3]; // [R10] [R15]
   assign rsv = hid[RSV_BIT];
   assign dp = hid[DP_BIT];
   assign pf = hid[PF_LSB +: 8];
   assign ps = hid[PS_LSB +: 8];
   assign sa = hid[SA_LSB +: 8];
   assign pdu1 = (pf < PF_BCAST_MIN); // [R12] [R13]

   // Read data multiplexer; head registers read zero while the queue is empty
   always_comb begin
      rd_d = 32'h0000_0000;
      unique case (avs_address)
         REG_CTRL: rd_d[CTRL_SETUP] = armed_q;
         REG_STATUS, REG_POP: begin
            rd_d[CNT_W-1:0] = cnt_q; // [R4]
            rd_d[STS_LOST] = lost_q;
            rd_d[STS_ARMED] = armed_q;
         end
         REG_ID: rd_d = (cnt_q != CNT_RST) ? {3'h0, hid} : 32'h0000_0000; // [R16]
         REG_DATA_LO: rd_d = (cnt_q != CNT_RST) ? mem_data[rd_ptr_q][31:0] : 32'h0000_0000;
         REG_DATA_HI: rd_d = (cnt_q != CNT_RST) ? mem_data[rd_ptr_q][63:32] : 32'h0000_0000;
         REG_DLC: rd_d[3:0] = (cnt_q != CNT_RST) ? mem_dlc[rd_ptr_q] : 4'h0; // [R3]
         REG_DECODE: begin
            if (cnt_q != CNT_RST) begin
               rd_d[SA_LSB +: 8] = sa; // [R10]
               rd_d[PS_LSB +: 8] = ps;
               rd_d[PF_LSB +: 8] = pf;
               rd_d[DP_BIT] = dp;
               rd_d[RSV_BIT] = rsv;
               rd_d[PRIO_LSB +: 3] = prio;
               rd_d[DEC_PDU1] = pdu1; // [R12]
               rd_d[DEC_PDU2] = ~pdu1; // [R13]
            end
         end
         REG_PGN: rd_d = (cnt_q != CNT_RST) ? {14'h0000, rsv, dp, pf, ps} : 32'h0000_0000; // [R11]
         REG_IRQ_STS: rd_d[IRQ_W-1:0] = irq_sts_q;
         REG_IRQ_MASK: rd_d[IRQ_W-1:0] = irq_mask_q;
         default: rd_d = 32'h0000_0000;
      endcase
   end

   // One wait state per access: data is captured while waitrequest is high
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else if (avs_waitrequest && (avs_read || avs_write)) begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= avs_read ? rd_d : 32'h0000_0000;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // Interrupt status: write one to clear, a new event wins over the clear
   assign irq_set = {drop | (arrive & full), push};
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq_sts_q <= '0;
      end else begin
         if (wr_done && avs_address == REG_IRQ_STS && avs_byteenable[0]) begin
            irq_sts_q <= (irq_sts_q & ~avs_writedata[IRQ_W-1:0]) | irq_set;
         end else begin
            irq_sts_q <= irq_sts_q | irq_set;
         end
      end
   end

   // Interrupt mask
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq_mask_q <= IRQ_MASK_RST;
      end else if (wr_done && avs_address == REG_IRQ_MASK && avs_byteenable[0]) begin
         irq_mask_q <= avs_writedata[IRQ_W-1:0];
      end
   end

   // Level interrupt, one cycle behind the status bits
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_sts_q & irq_mask_q);
      end
   end

   // Checks on the queue, decoding and bus timing
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   AST_SETUP_ARMS: assert property (setup_p |=> armed_q) // [R1]
      else $error("setup pulse did not arm reception");
   AST_UNARMED_IGNORED: assert property (!armed_q && frm_valid && !pop && !flush_p |=> cnt_q == $past(cnt_q)) // [R1]
      else $error("frame taken before setup");
   AST_FLUSH_EMPTIES: assert property (flush_p |=> cnt_q == CNT_RST ##1 cnt_q <= 5'h01) // [R2]
      else $error("flush left frames queued");
   AST_DLC_LIMIT: assert property (cnt_q != CNT_RST |-> mem_dlc[rd_ptr_q] <= DLC_MAX) // [R3]
      else $error("stored length code above eight");
   AST_POP_DECREMENTS: assert property (pop && !push |=> cnt_q == $past(cnt_q) - 5'h01) // [R5]
      else $error("pop did not lower count by one");
   AST_PUSH_INCREMENTS: assert property (push && !pop |=> cnt_q == $past(cnt_q) + 5'h01) // [R4]
      else $error("push did not raise count by one");
   AST_LOST_ON_FULL: assert property (arrive && full |=> lost_q && irq_sts_q[IRQ_LOST]) // [R6]
      else $error("drop on full queue not flagged");
   AST_DEPTH_BOUND: assert property (cnt_q <= CNT_W'(DEPTH)) // [R7]
      else $error("pending count beyond queue depth");
   AST_STD_REJECTED: assert property (frm_valid && !frm_ide && !pop && !flush_p |=> cnt_q == $past(cnt_q)) // [R8]
      else $error("standard frame was queued");
   AST_ID_TOP_ZERO: assert property (avs_read && avs_waitrequest && avs_address == REG_ID |=> avs_readdata[31:29] == 3'h0) // [R16]
      else $error("identifier word upper bits set");
   AST_CLASS: assert property (cnt_q != CNT_RST |-> pdu1 == (hid[23:16] <= 8'hef)) // [R12] [R13]
      else $error("PDU class wrong for PDU format");
   AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not after one wait state");


   // Helper terms for the checks below
   logic pop_try;
   logic rd_cap;
   logic head_ok;
   assign pop_try = rd_done & (avs_address == REG_POP);
   assign rd_cap = avs_read & avs_waitrequest; // Edge at which readdata is loaded
   assign head_ok = (cnt_q != CNT_RST);

   // Arming is one shot and is only undone by reset
   AST_ARMED_HOLDS: assert property (armed_q |=> armed_q) // [R1]
      else $error("reception disarmed without reset");
   // Lost flag is sticky and only a drop on a full queue sets it
   AST_LOST_STICKY: assert property (lost_q && !flush_p && !setup_p |=> lost_q) // [R6]
      else $error("lost flag dropped without a clear");
   AST_LOST_ONLY_ON_DROP: assert property (!lost_q && !(arrive && full) |=> !lost_q) // [R6]
      else $error("lost flag set while the queue had room");
   AST_FULL_BLOCKS_PUSH: assert property (full |-> !push) // [R7]
      else $error("frame stored into a full queue");

   // Count moves only on push, pop or flush; a pop on empty is ignored
   AST_COUNT_HOLDS: assert property (!push && !pop && !flush_p |=> cnt_q == $past(cnt_q)) // [R4]
      else $error("pending count moved with no event");
   AST_POP_EMPTY_HOLD: assert property (pop_try && !head_ok && !push |=> cnt_q == CNT_RST) // [R5]
      else $error("pop on empty queue changed the count");

   // Shadow tally kept apart from the pointer logic, so a slip in either shows
   logic [CNT_W-1:0] tally_q;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tally_q <= CNT_RST;
      end else if (flush_p) begin
         tally_q <= CNT_RST;
      end else begin
         tally_q <= tally_q + CNT_W'(push) - CNT_W'(pop);
      end
   end
   AST_TALLY_MATCH: assert property (cnt_q == tally_q) // [R4] [R5]
      else $error("pending count differs from frames taken minus popped");

   // A frame landing in an empty queue becomes the head, its length code limited to eight
   AST_HEAD_ID: assert property (push && !head_ok |=> hid == $past({frm_base_id, frm_ext_id})) // [R9]
      else $error("head identifier is not base then extension");
   AST_DLC_CLAMP: assert property (push && !head_ok && frm_dlc > DLC_MAX |=> mem_dlc[rd_ptr_q] == DLC_MAX) // [R3]
      else $error("length code above eight not limited");
   AST_DLC_KEPT: assert property (push && !head_ok && frm_dlc <= DLC_MAX // [R3]
      |=> mem_dlc[rd_ptr_q] == $past(frm_dlc))
      else $error("length code not stored as sent");

   // Read words as the bus sees them one edge after capture
   AST_ID_WORD: assert property (rd_cap && avs_address == REG_ID && head_ok // [R9] [R16]
      |=> avs_readdata == {3'h0, $past(hid)})
      else $error("identifier word differs from head frame");
   AST_PGN_WORD: assert property (rd_cap && avs_address == REG_PGN && head_ok // [R11]
      |=> avs_readdata == {14'h0000, $past(hid[RSV_BIT:PS_LSB])})
      else $error("group number not built from PF and PS");
   AST_CLASS_WORD: assert property (rd_cap && avs_address == REG_DECODE && head_ok // [R12] [R13]
      |=> avs_readdata[DEC_PDU1] != avs_readdata[DEC_PDU2])
      else $error("frame not in exactly one PDU class");
   AST_DLC_WORD: assert property (rd_cap && avs_address == REG_DLC |=> avs_readdata <= 32'(DLC_MAX)) // [R3]
      else $error("length code word above eight");
   AST_EMPTY_HEAD: assert property (rd_cap && avs_address == REG_ID && !head_ok // [R4]
      |=> avs_readdata == 32'h0000_0000)
      else $error("identifier word not zero on empty queue");

   // Bus and interrupt timing
   AST_IDLE_WAITS: assert property (!avs_read && !avs_write |=> avs_waitrequest)
      else $error("waitrequest low with no request");
   AST_RX_EVENT: assert property (push |=> irq_sts_q[IRQ_RX])
      else $error("received frame not flagged in status");
   AST_IRQ_LEVEL: assert property (irq == $past(|(irq_sts_q & irq_mask_q)))
      else $error("interrupt does not follow unmasked status");

   COV_FILL: cover property (drop);
   COV_POP_PUSH: cover property (pop && push);
   COV_BCAST_HEAD: cover property (cnt_q != CNT_RST && !pdu1 && rd_done && avs_address == REG_DECODE);
   COV_PDU1_HEAD: cover property (head_ok && pdu1 && rd_done && avs_address == REG_DECODE);
   COV_FLUSH_BUSY: cover property (flush_p && head_ok);
endmodule

// >>> sim/can_node_model.sv
// Behavioural CAN node that hands received frames to the queue as strobes.
// Assumes send is called right after a rising edge of clk_sys.
`timescale 1ns/10ps
module can_node_model (
   // Clock
   input wire logic clk_sys,
   // Frame strobe toward the receive queue
   output logic frm_valid,
   output logic frm_ide,
   output logic [j1939_rx_pkg::BASE_W-1:0] frm_base_id,
   output logic [j1939_rx_pkg::EXT_W-1:0] frm_ext_id,
   output logic [3:0] frm_dlc,
   output logic [63:0] frm_data
);
   import j1939_rx_pkg::*;

   // Idle fields at time zero
   initial begin
      frm_valid = 1'b0;
      frm_ide = 1'b0;
      frm_base_id = '0;
      frm_ext_id = '0;
      frm_dlc = 4'h0;
      frm_data = 64'h0;
   end

   // One frame, one cycle; stale fields are inverted so nothing leans on them
   task automatic send(input logic [ID_W-1:0] id, input logic ide, input logic [3:0] dlc, input logic [63:0] d);
      frm_valid <= 1'b1;
      frm_ide <= ide;
      frm_base_id <= id[28:18];
      frm_ext_id <= id[17:0];
      frm_dlc <= dlc;
      frm_data <= d;
      @(posedge clk_sys);
      frm_valid <= 1'b0;
      frm_ide <= ~ide;
      frm_base_id <= ~id[28:18];
      frm_ext_id <= ~id[17:0];
      frm_dlc <= ~dlc;
      frm_data <= ~d;
      // Gap edge so a following send never rewrites the strobe in one step
      @(posedge clk_sys);
   endtask
endmodule

// >>> sim/tb.sv
// Self-checking bench for the extended-frame receive queue.
// Assumes the CAN node model drives the frame port; bench is the bus master.
`timescale 1ns/10ps
module tb;
   import j1939_rx_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic frm_valid, frm_ide, irq;
   logic [BASE_W-1:0] frm_base_id;
   logic [EXT_W-1:0] frm_ext_id;
   logic [3:0] frm_dlc;
   logic [63:0] frm_data;
   int num_errors = 0;
   int compares = 0;
   logic [31:0] q;

   // 40 MHz system clock
   always #12.5 clk_sys = ~clk_sys;

   extended_receive_all_block uut (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .frm_valid(frm_valid),
      .frm_ide(frm_ide), .frm_base_id(frm_base_id), .frm_ext_id(frm_ext_id), .frm_dlc(frm_dlc),
      .frm_data(frm_data), .irq(irq));

   can_node_model node (.clk_sys(clk_sys), .frm_valid(frm_valid), .frm_ide(frm_ide),
      .frm_base_id(frm_base_id), .frm_ext_id(frm_ext_id), .frm_dlc(frm_dlc), .frm_data(frm_data));

   task automatic close_out;
      if (num_errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One bus access; held until waitrequest is seen low, then an idle edge
   task automatic av(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int n;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= d;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_sys);
         if (avs_waitrequest === 1'b0) break;
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk_sys);
      if (n == 20) begin
         num_errors++;
         close_out();
      end
   endtask

   task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
      av(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask

   // Frames before arming and standard frames leave the queue empty
   task automatic t_arming;
      node.send(29'h0cf00203, 1'b1, 4'h8, 64'h1);
      rd_chk("unarmed", REG_STATUS, 32'h0);
      av(1'b1, REG_CTRL, 32'h1);
      rd_chk("armed", REG_STATUS, 32'h200);
      rd_chk("ctrl", REG_CTRL, 32'h1);
      rd_chk("unmapped", 6'h3c, 32'h0);
      node.send(29'h0cf00203, 1'b0, 4'h8, 64'h1);
      rd_chk("std frame", REG_STATUS, 32'h200);
   endtask

   // One frame through the decoder, then popped
   task automatic t_decode(input logic [ID_W-1:0] id, input logic [3:0] dlc, input logic [3:0] edlc);
      logic p2;
      p2 = (id[23:16] >= 8'hf0);
      node.send(id, 1'b1, dlc, 64'h8877665544332211);
      rd_chk("id", REG_ID, {3'h0, id});
      rd_chk("decode", REG_DECODE, {1'b0, p2, ~p2, id});
      rd_chk("pgn", REG_PGN, {14'h0, id[25:8]});
      rd_chk("dlc", REG_DLC, {28'h0, edlc});
      rd_chk("data lo", REG_DATA_LO, 32'h44332211);
      rd_chk("data hi", REG_DATA_HI, 32'h88776655);
      rd_chk("pop", REG_POP, 32'h201);
      rd_chk("after pop", REG_STATUS, 32'h200);
   endtask

   // Unmasked receive event raises irq; write-one-to-clear drops it
   task automatic t_irq;
      // Earlier frames left the receive bit set; clear it so the event is fresh
      av(1'b1, REG_IRQ_STS, 32'h3);
      av(1'b1, REG_IRQ_MASK, 32'h3);
      chk("irq idle", 32'h0, {31'h0, irq});
      node.send(29'h18ef1234, 1'b1, 4'h2, 64'h0);
      @(posedge clk_sys);
      chk("irq high", 32'h1, {31'h0, irq});
      rd_chk("irq rx", REG_IRQ_STS, 32'h1);
      av(1'b1, REG_IRQ_STS, 32'h1);
      @(posedge clk_sys);
      chk("irq low", 32'h0, {31'h0, irq});
      rd_chk("pop", REG_POP, 32'h201);
   endtask

   // Seventeen frames overflow the sixteen-deep queue; flush empties it
   task automatic t_overflow;
      for (int i = 0; i < 17; i++) node.send(29'h0cf00203, 1'b1, 4'h1, 64'(i));
      rd_chk("full", REG_STATUS, 32'h310);
      rd_chk("irq sts", REG_IRQ_STS, 32'h3);
      rd_chk("pop", REG_POP, 32'h310);
      rd_chk("popped", REG_STATUS, 32'h30f);
      rd_chk("fifo order", REG_DATA_LO, 32'h1);
      av(1'b1, REG_CTRL, 32'h2);
      rd_chk("flushed", REG_STATUS, 32'h200);
      rd_chk("empty id", REG_ID, 32'h0);
      av(1'b1, REG_IRQ_STS, 32'h3);
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      t_arming();
      t_decode(29'h0cf00203, 4'h8, 4'h8);
      t_decode(29'h18ef1234, 4'hf, 4'h8);
      t_decode(29'h1cf0abcd, 4'h0, 4'h0);
      t_irq();
      t_overflow();
      close_out();
   end
endmodule
